//--- rtl/ubm_pkg.sv
// Package with register map, field layout and types of the endpoint-2 buffer manager.
package ubm_pkg;

   // ---------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_COP_CTRL  = 8'h1c;
   localparam logic [7:0] IDX_COP_FLAGS = 8'h1d;
   localparam logic [7:0] IDX_COP_PTR   = 8'h1f;
   localparam logic [7:0] IDX_BUF_CSR   = 8'h20;
   localparam logic [7:0] IDX_EP2_CTRL  = 8'h21;

   // ---------------------------------------------------------------
   // Field positions.
   // ---------------------------------------------------------------
   localparam int CTRL_RUN    = 0;
   localparam int CTRL_INIT   = 1;
   localparam int CTRL_LOAD   = 2;
   localparam int CTRL_HALTEN = 3;
   localparam int CTRL_ERROR_IRQ_ENABLE  = 4;
   localparam int FLG_HALT    = 0;
   localparam int FLG_ERR     = 1;
   localparam int BUF_CLR     = 0;
   localparam int BUF_STAT_LO = 1;
   localparam int BUF_NUM     = 3;
   localparam int EP2_MODE_LO = 0;
   localparam int EP2_RX_VAL  = 2;
   localparam int EP2_TX_VAL  = 3;

   // ---------------------------------------------------------------
   // Reset values and sizes.
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_COP_CTRL = 8'h00;
   localparam logic [7:0] RST_COP_PTR  = 8'h00;
   localparam logic [1:0] RST_FLAGS    = 2'h0;
   localparam int EP01_BUF_BYTES = 16;
   localparam int EP2_PKT_BYTES  = 64;
   localparam int BLOCK_BYTES    = 512;
   localparam logic [2:0] LAST_PKT = 3'(BLOCK_BYTES / EP2_PKT_BYTES - 1);

   // ---------------------------------------------------------------
   // Types.
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL   = 2'h0,
      MODE_UPLOAD   = 2'h1,
      MODE_DOWNLOAD = 2'h2
   } ubm_mode_t;

   typedef enum logic [1:0] {
      HS_ACK     = 2'h0,
      HS_NAK     = 2'h1,
      HS_INVALID = 2'h2
   } ubm_hs_t;

   typedef enum logic [2:0] {
      BM_NORMAL = 3'h1,
      BM_ACTIVE = 3'h2,
      BM_WAIT   = 3'h4
   } ubm_bm_state_t;

   typedef struct packed {
      logic done;
      logic dir_in;
      logic short_pkt;
      logic ep_valid;
   } ubm_usb_evt_t;

   typedef struct packed {
      logic release_blk;
      logic blk_idx;
   } ubm_cop_rel_t;

endpackage

//--- rtl/ubm_top.sv
// Endpoint-2 double buffer manager with the transfer coprocessor control registers.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ubm_top (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [9:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  cop_error_evt,
   input  wire logic                  cop_stop_evt,
   input  wire ubm_pkg::ubm_cop_rel_t cop_rel,
   output logic                       cop_run,
   output logic                       cop_ram_wr_en,
   output logic                       cop_entry_load,
   output logic      [7:0]            cop_entry_address,
   output logic                       cop_irq,
   input  wire ubm_pkg::ubm_usb_evt_t usb_evt,
   output ubm_pkg::ubm_hs_t           ep2_rx_hs,
   output ubm_pkg::ubm_hs_t           ep2_tx_hs,
   output logic      [9:0]            ep2_buf_addr,
   output logic                       usb_xact_irq,
   input  wire logic                  halt_mode,
   input  wire logic                  usb_suspended,
   input  wire logic                  usb_bus_activity,
   output logic                       suspend_end_event,
   input  wire logic [2:0]            buf_req,
   output logic      [2:0]            buf_grant
);

   // ---------------------------------------------------------------
   // APB slave: one wait state, registered answer.
   // ---------------------------------------------------------------
   logic       pready_r;
   logic       pslverr_r;
   logic [31:0] prdata_r;
   logic       apb_done;
   logic       apb_hit;
   logic [7:0] idx;
   logic [7:0] rd_val;
   logic       wr_ctrl;
   logic       wr_ptr;
   logic       wr_buf;
   logic       wr_ep2;
   logic       rd_flags;

   logic [7:0]              ctrl_r;
   logic [7:0]              ptr_r;
   logic [1:0]              flags_r;
   logic                    cur_r;
   logic [1:0]              statb_r;
   logic [2:0]              pkt_r;
   ubm_pkg::ubm_bm_state_t  bm_r;
   ubm_pkg::ubm_mode_t      mode_r;
   logic [1:0]              val_r;
   ubm_pkg::ubm_hs_t        rx_hs_r;
   ubm_pkg::ubm_hs_t        tx_hs_r;
   logic                    xirq_r;
   logic                    cirq_r;
   logic                    entry_ld_r;
   logic [7:0]              entry_r;
   logic [2:0]              act_r;
   logic                    wake_r;
   logic [2:0]              grant_r;

   assign idx      = paddr[9:2];
   assign apb_done = psel && penable && pready_r;
   assign apb_hit  = idx inside {ubm_pkg::IDX_COP_CTRL, ubm_pkg::IDX_COP_FLAGS,
                                 ubm_pkg::IDX_COP_PTR, ubm_pkg::IDX_BUF_CSR,
                                 ubm_pkg::IDX_EP2_CTRL};
   assign wr_ctrl  = apb_done && pwrite && idx == ubm_pkg::IDX_COP_CTRL;
   assign wr_ptr   = apb_done && pwrite && idx == ubm_pkg::IDX_COP_PTR;
   assign wr_buf   = apb_done && pwrite && idx == ubm_pkg::IDX_BUF_CSR;
   assign wr_ep2   = apb_done && pwrite && idx == ubm_pkg::IDX_EP2_CTRL;
   assign rd_flags = apb_done && !pwrite && idx == ubm_pkg::IDX_COP_FLAGS;

   // Read mux; the entry pointer is write-only and the clear bit reads zero.
   always_comb
   begin
      unique case (idx)
         ubm_pkg::IDX_COP_CTRL:  rd_val = ctrl_r;
         ubm_pkg::IDX_COP_FLAGS: rd_val = {6'h00, flags_r};
         ubm_pkg::IDX_BUF_CSR:   rd_val = {4'h0, cur_r, statb_r, 1'b0};
         ubm_pkg::IDX_EP2_CTRL:  rd_val = {4'h0, val_r, mode_r};
         default:                rd_val = 8'h00;
      endcase
   end

   // Answer is prepared in the first access cycle and completes in the next.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else
      begin
         pready_r  <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !apb_hit;
         prdata_r  <= (psel && penable && !pready_r) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Coprocessor control, pointer and event flags.
   // ---------------------------------------------------------------
   // Run and load lock each other out; a write that asks for both while stopped
   // takes the load and keeps run low, because starting a half-loaded program is
   // never wanted. While running, the load request is dropped and run takes the written run bit.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_r <= ubm_pkg::RST_COP_CTRL;
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_r[7:5]                  <= 3'h0;
            ctrl_r[ubm_pkg::CTRL_ERROR_IRQ_ENABLE]  <= pwdata[ubm_pkg::CTRL_ERROR_IRQ_ENABLE];
            ctrl_r[ubm_pkg::CTRL_HALTEN] <= pwdata[ubm_pkg::CTRL_HALTEN];
            ctrl_r[ubm_pkg::CTRL_INIT]   <= pwdata[ubm_pkg::CTRL_INIT];
            ctrl_r[ubm_pkg::CTRL_LOAD]   <= pwdata[ubm_pkg::CTRL_LOAD]
                                            & (~ctrl_r[ubm_pkg::CTRL_RUN]
                                               | ctrl_r[ubm_pkg::CTRL_LOAD]);
         end
         if (cop_stop_evt)
            ctrl_r[ubm_pkg::CTRL_RUN] <= 1'b0;
         else if (wr_ctrl)
            ctrl_r[ubm_pkg::CTRL_RUN] <= pwdata[ubm_pkg::CTRL_RUN]
                                         & ~ctrl_r[ubm_pkg::CTRL_LOAD]
                                         & ~(pwdata[ubm_pkg::CTRL_LOAD]
                                             & ~ctrl_r[ubm_pkg::CTRL_RUN]);
      end
   end

   // Entry pointer is only ever written by software.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ptr_r <= ubm_pkg::RST_COP_PTR;
      else if (wr_ptr)
         ptr_r <= pwdata[7:0];
   end

   // Flags: a hardware event in the cycle of the clearing read still lands.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_r <= ubm_pkg::RST_FLAGS;
      else
      begin
         flags_r[ubm_pkg::FLG_ERR]  <= (flags_r[ubm_pkg::FLG_ERR] & ~rd_flags)
                                       | (cop_error_evt & ctrl_r[ubm_pkg::CTRL_RUN]);
         flags_r[ubm_pkg::FLG_HALT] <= (flags_r[ubm_pkg::FLG_HALT] & ~rd_flags)
                                       | cop_stop_evt;
      end
   end

   // Coprocessor-facing outputs; the pointer is copied on every cycle init is high.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cirq_r     <= 1'b0;
         entry_ld_r <= 1'b0;
         entry_r    <= ubm_pkg::RST_COP_PTR;
      end
      else
      begin
         cirq_r     <= (flags_r[ubm_pkg::FLG_ERR] & ctrl_r[ubm_pkg::CTRL_ERROR_IRQ_ENABLE])
                     | (flags_r[ubm_pkg::FLG_HALT] & ctrl_r[ubm_pkg::CTRL_HALTEN]);
         entry_ld_r <= ctrl_r[ubm_pkg::CTRL_INIT];
         if (ctrl_r[ubm_pkg::CTRL_INIT])
            entry_r <= ptr_r;
      end
   end

   // ---------------------------------------------------------------
   // Endpoint-2 buffer manager.
   // ---------------------------------------------------------------
   // A block is usable by USB when full in upload mode or empty in download mode.
   function automatic logic blk_ready(input ubm_pkg::ubm_mode_t m, input logic st);
      blk_ready = (m == ubm_pkg::MODE_UPLOAD) ? st : ~st;
   endfunction

   logic usb_live;
   logic stream_dir;
   logic stream_xact;
   logic blk_end;
   logic [1:0] st_set;
   logic [1:0] st_clr;

   // Halt mode freezes the USB side: no transaction is taken.
   assign usb_live    = usb_evt.done && usb_evt.ep_valid && !halt_mode;
   assign stream_dir  = (mode_r == ubm_pkg::MODE_UPLOAD) == usb_evt.dir_in;
   assign stream_xact = usb_live && stream_dir && bm_r == ubm_pkg::BM_ACTIVE
                        && blk_ready(mode_r, statb_r[cur_r]);
   assign blk_end     = stream_xact && !usb_evt.short_pkt && pkt_r == ubm_pkg::LAST_PKT;

   // Status bits: releases set in upload and clear in download; block ends do the opposite; the clear bit resets both.
   always_comb
   begin
      st_set = 2'h0;
      st_clr = wr_buf && pwdata[ubm_pkg::BUF_CLR] ? 2'h3 : 2'h0;
      if (cop_rel.release_blk)
      begin
         if (mode_r == ubm_pkg::MODE_UPLOAD)
            st_set[cop_rel.blk_idx] = 1'b1;
         else
            st_clr[cop_rel.blk_idx] = 1'b1;
      end
      if (blk_end)
      begin
         if (mode_r == ubm_pkg::MODE_UPLOAD)
            st_clr[cur_r] = 1'b1;
         else
            st_set[cur_r] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         statb_r <= 2'h0;
      else
         statb_r <= (statb_r & ~st_clr) | st_set;
   end

   // Block index, packet counter and manager state.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cur_r <= 1'b0;
         pkt_r <= 3'h0;
         bm_r  <= ubm_pkg::BM_NORMAL;
      end
      else if (wr_buf && pwdata[ubm_pkg::BUF_CLR])
      begin
         cur_r <= 1'b0;
         pkt_r <= 3'h0;
         bm_r  <= (mode_r == ubm_pkg::MODE_NORMAL) ? ubm_pkg::BM_NORMAL : ubm_pkg::BM_ACTIVE;
      end
      else
      begin
         unique case (bm_r)
            ubm_pkg::BM_NORMAL:
               if (mode_r != ubm_pkg::MODE_NORMAL)
                  bm_r <= ubm_pkg::BM_ACTIVE;
            ubm_pkg::BM_ACTIVE:
               if (mode_r == ubm_pkg::MODE_NORMAL)
                  bm_r <= ubm_pkg::BM_NORMAL;
               else if (stream_xact && usb_evt.short_pkt)
                  bm_r <= ubm_pkg::BM_NORMAL;
               else if (blk_end)
               begin
                  pkt_r <= 3'h0;
                  cur_r <= ~cur_r;
                  bm_r  <= blk_ready(mode_r, statb_r[~cur_r]) ? ubm_pkg::BM_ACTIVE
                                                              : ubm_pkg::BM_WAIT;
               end
               else if (stream_xact)
                  pkt_r <= pkt_r + 3'h1;
            ubm_pkg::BM_WAIT:
               if (mode_r == ubm_pkg::MODE_NORMAL)
                  bm_r <= ubm_pkg::BM_NORMAL;
               else if (blk_ready(mode_r, statb_r[cur_r]))
                  bm_r <= ubm_pkg::BM_ACTIVE;
         endcase
      end
   end

   // Mode field and normal-mode valid bits; hardware NAKs a direction after each
   // transfer, and its clear overrides a software set in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r <= ubm_pkg::MODE_NORMAL;
         val_r  <= 2'h0;
      end
      else
      begin
         if (wr_ep2)
         begin
            mode_r <= ubm_pkg::ubm_mode_t'(pwdata[ubm_pkg::EP2_MODE_LO +: 2]);
            val_r  <= pwdata[ubm_pkg::EP2_RX_VAL +: 2];
         end
         if (stream_xact && usb_evt.short_pkt)
            mode_r <= ubm_pkg::MODE_NORMAL;
         if (usb_live && mode_r == ubm_pkg::MODE_NORMAL)
            val_r[usb_evt.dir_in] <= 1'b0;
      end
   end

   // Handshakes seen by the protocol engine for the next token.
   function automatic ubm_pkg::ubm_hs_t stream_hs(input logic dir_in);
      if (mode_r == ubm_pkg::MODE_NORMAL)
         stream_hs = val_r[dir_in] ? ubm_pkg::HS_ACK : ubm_pkg::HS_NAK;
      else if ((mode_r == ubm_pkg::MODE_UPLOAD) != dir_in)
         stream_hs = ubm_pkg::HS_NAK;
      else if (bm_r == ubm_pkg::BM_WAIT)
         stream_hs = ubm_pkg::HS_INVALID;
      else if (bm_r == ubm_pkg::BM_ACTIVE && blk_ready(mode_r, statb_r[cur_r]))
         stream_hs = ubm_pkg::HS_ACK;
      else
         stream_hs = ubm_pkg::HS_NAK;
   endfunction

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_hs_r <= ubm_pkg::HS_NAK;
         tx_hs_r <= ubm_pkg::HS_NAK;
         xirq_r  <= 1'b0;
      end
      else
      begin
         rx_hs_r <= stream_hs(1'b0);
         tx_hs_r <= stream_hs(1'b1);
         xirq_r  <= usb_live && mode_r == ubm_pkg::MODE_NORMAL;
      end
   end

   // ---------------------------------------------------------------
   // Suspend wake-up and buffer arbitration.
   // ---------------------------------------------------------------
   // Bus activity is a pin: two flops, then an edge detector on the second.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_r  <= 3'h0;
         wake_r <= 1'b0;
      end
      else
      begin
         act_r  <= {act_r[1:0], usb_bus_activity};
         wake_r <= usb_suspended && act_r[1] && !act_r[2];
      end
   end

   // Ownership lasts until the owner drops its request; bit 0 wins ties.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         grant_r <= 3'h0;
      else if ((grant_r & buf_req) == 3'h0)
         grant_r <= buf_req & (~buf_req + 3'h1);
   end

   assign prdata            = prdata_r;
   assign pready            = pready_r;
   assign pslverr           = pslverr_r;
   assign cop_run           = ctrl_r[ubm_pkg::CTRL_RUN];
   assign cop_ram_wr_en     = ctrl_r[ubm_pkg::CTRL_LOAD];
   assign cop_entry_load    = entry_ld_r;
   assign cop_entry_address = entry_r;
   assign cop_irq           = cirq_r;
   assign ep2_rx_hs         = rx_hs_r;
   assign ep2_tx_hs         = tx_hs_r;
   assign ep2_buf_addr      = {cur_r, pkt_r, 6'h00};
   assign usb_xact_irq      = xirq_r;
   assign suspend_end_event = wake_r;
   assign buf_grant         = grant_r;

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   sequence s_flags_read;
      rd_flags && !cop_error_evt && !cop_stop_evt;
   endsequence

   a_err_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r[ubm_pkg::CTRL_ERROR_IRQ_ENABLE] && !ctrl_r[ubm_pkg::CTRL_HALTEN] |=> !cop_irq)
      else $error("coprocessor irq raised while both enables are clear");
   a_stop_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      flags_r[ubm_pkg::FLG_HALT] && ctrl_r[ubm_pkg::CTRL_HALTEN] |=> cop_irq)
      else $error("stop flag with enable did not raise irq");
   a_load_locked: assert property (@(posedge pclk) disable iff (!presetn)
      cop_run && !cop_ram_wr_en |=> !cop_ram_wr_en)
      else $error("load enabled while running");
   a_run_locked: assert property (@(posedge pclk) disable iff (!presetn)
      cop_ram_wr_en |=> !cop_run)
      else $error("run set while load enabled");
   a_stop_run: assert property (@(posedge pclk) disable iff (!presetn)
      cop_stop_evt |=> !cop_run && flags_r[ubm_pkg::FLG_HALT])
      else $error("stop event left run set or flag clear");
   a_entry_copy: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[ubm_pkg::CTRL_INIT] |=> cop_entry_address == $past(ptr_r))
      else $error("entry pointer not copied");
   a_err_flag: assert property (@(posedge pclk) disable iff (!presetn)
      cop_error_evt && cop_run |=> flags_r[ubm_pkg::FLG_ERR])
      else $error("error flag not set");
   a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
      s_flags_read |=> flags_r == 2'h0)
      else $error("flag read did not clear");
   a_nak_after: assert property (@(posedge pclk) disable iff (!presetn)
      usb_live && mode_r == ubm_pkg::MODE_NORMAL && !wr_ep2 |=> ##1
      ($past(usb_evt.dir_in, 2) ? ep2_tx_hs : ep2_rx_hs) == ubm_pkg::HS_NAK)
      else $error("normal mode transfer not followed by nak");
   a_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
      wr_buf && pwdata[ubm_pkg::BUF_CLR] && !cop_rel.release_blk |=>
      !cur_r && pkt_r == 3'h0 && statb_r == 2'h0)
      else $error("buffer clear incomplete");
   a_core_first: assert property (@(posedge pclk) disable iff (!presetn)
      buf_req[0] && (grant_r & buf_req) == 3'h0 |=> buf_grant == 3'h1)
      else $error("core not granted first");

endmodule

`default_nettype wire

//--- test/ubm_cop_model.sv
// Stand-in for the transfer coprocessor: event pulses and block releases.
`timescale 1ns/1ps
`default_nettype none

module ubm_cop_model (
   input  wire logic             pclk,
   output logic                  err_evt,
   output logic                  stop_evt,
   output ubm_pkg::ubm_cop_rel_t rel
);
   // Idle outputs from time zero so the manager never sees an unknown event.
   initial
   begin
      err_evt  = 1'b0;
      stop_evt = 1'b0;
      rel      = '0;
   end

   // One-cycle event pulse; bit 0 is a stop, bit 1 an error.
   task automatic pulse(input logic [1:0] k);
      @(posedge pclk);
      stop_evt <= k[0];
      err_evt  <= k[1];
      @(posedge pclk);
      stop_evt <= 1'b0;
      err_evt  <= 1'b0;
   endtask

   // Hands a block back; a single pulse, since the manager latches it.
   task automatic give(input logic b);
      @(posedge pclk);
      rel <= '{1'b1, b};
      @(posedge pclk);
      rel <= '0;
   endtask
endmodule

`default_nettype wire

//--- test/ubm_top_tb.sv
// Self-checking bench for the endpoint-2 buffer manager and its registers.
`timescale 1ns/1ps
`default_nettype none

module ubm_top_tb;
   localparam logic [7:0] C = ubm_pkg::IDX_COP_CTRL;
   localparam logic [7:0] F = ubm_pkg::IDX_COP_FLAGS;
   localparam logic [7:0] B = ubm_pkg::IDX_BUF_CSR;
   logic                  pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [9:0]            paddr = '0, baddr;
   logic [31:0]           pwdata = '0, prdata, rdat;
   logic                  pready, pslverr, rerr, run, we, eld, irq, xirq, err_e, stop_e;
   logic [7:0]            ea, d;
   logic [2:0]            req = '0, gnt;
   logic                  halt = 0, susp = 0, act = 0, wk;
   ubm_pkg::ubm_cop_rel_t rel;
   ubm_pkg::ubm_usb_evt_t usb = '0;
   ubm_pkg::ubm_hs_t      rxh, txh;
   int                    bad_count = 0, total_checks = 0;

   // Free-running 40 MHz clock.
   always #12.5 pclk = ~pclk;

   ubm_top ubm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cop_error_evt(err_e), .cop_stop_evt(stop_e), .cop_rel(rel),
      .cop_run(run), .cop_ram_wr_en(we), .cop_entry_load(eld), .cop_entry_address(ea),
      .cop_irq(irq), .usb_evt(usb), .ep2_rx_hs(rxh), .ep2_tx_hs(txh), .ep2_buf_addr(baddr),
      .usb_xact_irq(xirq), .halt_mode(halt), .usb_suspended(susp),
      .usb_bus_activity(act), .suspend_end_event(wk), .buf_req(req), .buf_grant(gnt));
   ubm_cop_model cop_i (.pclk(pclk), .err_evt(err_e), .stop_evt(stop_e), .rel(rel));

   // Single comparison point; case inequality so an unknown never matches.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // APB transfer; the request is held until pready is seen high at a rising edge,
   // bounded so a hang ends the run.
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] v);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {idx, 2'b00};
      pwdata <= {24'h0, v};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge pclk);
      if (pready !== 1'b1)
      begin
         bad_count++;
         stop_test();
      end
      else
      begin
         rdat    = prdata;
         rerr    = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 8'h00);
      chk(rdat, e);
   endtask

   // One endpoint-2 transaction end, then look in the cycle that follows it.
   task automatic xact(input logic dir, input logic sh);
      @(posedge pclk);
      usb <= '{1'b1, dir, sh, 1'b1};
      @(posedge pclk);
      usb <= '0;
      @(negedge pclk);
   endtask

   // -----------------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h905db8be));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(txh, ubm_pkg::HS_NAK);
      rd(C, 32'h0);
      rd(F, 32'h0);
      rd(8'h30, 32'h0);
      chk(rerr, 1'b1);
      $display("end of reset and map test");
      // Load and run must refuse each other; reserved bits never stick.
      apb(1, C, 8'h01);
      apb(1, C, 8'h05);
      rd(C, 32'h01);
      apb(1, C, 8'h00);
      apb(1, C, 8'h04);
      apb(1, C, 8'h05);
      rd(C, 32'h04);
      d = 8'($urandom()) & 8'hfc;
      apb(1, C, d);
      rd(C, {24'h0, d & 8'h1c});
      chk(we, d[2]);
      d = 8'($urandom());
      apb(1, ubm_pkg::IDX_COP_PTR, d);
      rd(ubm_pkg::IDX_COP_PTR, 32'h0);
      apb(1, C, 8'h02);
      @(posedge pclk);
      @(negedge pclk);
      chk(ea, d);
      chk(eld, 1'b1);
      $display("end of control test");
      // Stop then error with its enable; flags clear on read.
      for (int k = 1; k < 3; k++)
      begin
         apb(1, C, k == 1 ? 8'h09 : 8'h11);
         cop_i.pulse(2'(k));
         @(posedge pclk);
         @(negedge pclk);
         chk(irq, 1'b1);
         chk(run, k == 2);
         rd(F, k);
         rd(F, 32'h0);
      end
      apb(1, C, 8'h01);
      cop_i.pulse(2'h3);
      @(posedge pclk);
      @(negedge pclk);
      chk(irq, 1'b0);
      rd(F, 32'h3);
      cop_i.pulse(2'h2);
      rd(F, 32'h0);
      $display("end of event test");
      // Normal mode: valid handshake, interrupt, then hardware NAK.
      apb(1, ubm_pkg::IDX_EP2_CTRL, 8'h08);
      repeat (2) @(negedge pclk);
      chk(txh, ubm_pkg::HS_ACK);
      xact(1'b1, 1'b0);
      chk(xirq, 1'b1);
      @(negedge pclk);
      chk(txh, ubm_pkg::HS_NAK);
      // Halt mode: the transaction is ignored, so valid stays and no interrupt comes.
      apb(1, ubm_pkg::IDX_EP2_CTRL, 8'h08);
      halt <= 1'b1;
      xact(1'b1, 1'b0);
      chk(xirq, 1'b0);
      chk(txh, ubm_pkg::HS_ACK);
      @(posedge pclk);
      halt <= 1'b0;
      // Upload mode: NAK until released, 64-byte steps, then invalid.
      apb(1, ubm_pkg::IDX_EP2_CTRL, 8'h01);
      repeat (2) @(negedge pclk);
      chk(txh, ubm_pkg::HS_NAK);
      cop_i.give(1'b0);
      repeat (2) @(negedge pclk);
      chk(txh, ubm_pkg::HS_ACK);
      for (int i = 0; i < 8; i++)
      begin
         chk(baddr, {1'b0, 3'(i), 6'h0});
         xact(1'b1, 1'b0);
         @(negedge pclk);
      end
      repeat (2) @(negedge pclk);
      chk(txh, ubm_pkg::HS_INVALID);
      chk(baddr, 10'h200);
      rd(B, 32'h08);
      apb(1, B, 8'h01);
      rd(B, 32'h0);
      // Download mode: one full packet, then a short one drops back to normal.
      apb(1, ubm_pkg::IDX_EP2_CTRL, 8'h02);
      repeat (2) @(negedge pclk);
      chk(rxh, ubm_pkg::HS_ACK);
      xact(1'b0, 1'b0);
      @(negedge pclk);
      chk(baddr, 10'h040);
      xact(1'b0, 1'b1);
      rd(ubm_pkg::IDX_EP2_CTRL, 32'h0);
      rd(B, 32'h0);
      $display("end of endpoint test");
      // Wake: bus activity only counts while suspended, after the two sync flops.
      for (int s = 0; s < 2; s++)
      begin
         @(posedge pclk);
         susp <= s[0];
         act  <= 1'b1;
         repeat (3) @(posedge pclk);
         @(negedge pclk);
         chk(wk, s[0]);
         @(posedge pclk);
         act <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      $display("end of wake test");
      // Arbiter: USB beats coprocessor and keeps the buffer against the core.
      req <= 3'b110;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk(gnt, 3'b010);
      @(posedge pclk);
      req <= 3'b111;
      repeat (2) @(negedge pclk);
      chk(gnt, 3'b010);
      $display("end of arbiter test");
      stop_test();
   end
endmodule

`default_nettype wire
